//--- dv/cmdd_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CMDD_CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module cmdd_top_test;
  import cmdd_pkg::*;
  // ----------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic int_base = 1'b0;
  logic ext_clk = 1'b0;
  logic ref_clk = 1'b0;
  logic int_stable = 1'b0;
  logic ext_stable = 1'b0;
  logic lf_add = 1'b0;
  logic lf_sub = 1'b0;
  logic [7:0] lf_step = 8'h00;
  logic int_run = 1'b1;
  logic ext_run = 1'b1;
  logic [5:0] pin_cnt = 6'h00;
  logic [31:0] prdata;
  logic pready, pslverr, int_on, ext_on, osc_sel, tb_sel, dco_tick;
  logic mon_irq, irq;
  logic [7:0] stage;
  logic [3:0] div;
  logic [7:0] m_stage = STAGE_RST;
  logic [3:0] m_div = DIV_RST;
  logic [32:0] apb_q[$];
  logic [11:0] lf_q[$];
  logic [32:0] apb_exp;
  logic [11:0] lf_exp;
  int miscompares = 0;
  int check_count = 0;
  int n;

  cmdd_top i_dut (.SYS_CLK_IN(sys_clk), .RESET_N_IN(reset_n),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .INT_BASE_IN(int_base),
    .EXT_REF_IN(ref_clk), .EXT_CLK_IN(ext_clk), .INT_REF_IN(ref_clk),
    .INTERNAL_STABLE_IN(int_stable), .EXTERNAL_STABLE_IN(ext_stable),
    .LF_ADD_IN(lf_add), .LF_SUB_IN(lf_sub), .LF_STEP_IN(lf_step),
    .INTERNAL_GEN_ON_OUT(int_on), .EXTERNAL_GEN_ON_OUT(ext_on),
    .OSC_SEL_EXT_OUT(osc_sel), .TIMEBASE_SEL_EXT_OUT(tb_sel),
    .STAGE_CONTROL_OUT(stage), .DIVIDER_CONTROL_OUT(div),
    .DCO_TICK_OUT(dco_tick), .MONITOR_IRQ_OUT(mon_irq), .IRQ_OUT(irq));

  // 125 MHz system clock
  always #4 sys_clk = ~sys_clk;

  // Both clocks fall every 8 cycles; the shared reference is far slower
  // External clock toggles at the same rate as the internal base clock
  always @(posedge sys_clk)
  begin
    pin_cnt <= pin_cnt + 6'h01;
    if (pin_cnt[1:0] == 2'h3 && int_run)
      int_base <= ~int_base;
    if (pin_cnt[1:0] == 2'h3 && ext_run)
      ext_clk <= ~ext_clk;
    if (pin_cnt == 6'h3F)
      ref_clk <= ~ref_clk;
  end

  // Watcher: results are compared on the falling edge, once settled
  always @(negedge sys_clk)
  begin
    if (pready === 1'b1 && psel && !pwrite && apb_q.size() > 0)
    begin
      apb_exp = apb_q.pop_front();
      `CMDD_CHK({pslverr, prdata}, apb_exp)
    end
    if (lf_q.size() > 0)
    begin
      lf_exp = lf_q.pop_front();
      `CMDD_CHK({div, stage}, lf_exp)
    end
  end

  // ----------------------------------------------------------
  // Bus and loop filter tasks
  // ----------------------------------------------------------
  task automatic results;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic timeout;
    miscompares++;
    $display("wait limit reached at %0t", $time);
    results();
  endtask : timeout

  // Request held unchanged until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr,
    input logic [31:0] wdata);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    @(posedge sys_clk);
    while (pready !== 1'b1 && k < 50)
    begin
      k++;
      @(posedge sys_clk);
    end
    if (k >= 50)
      timeout();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp,
    input logic err = 1'b0);
    apb_q.push_back({err, exp});
    apb(1'b0, addr, 32'h0);
  endtask : rd

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask : wr

  // One filter step; the model carries into or borrows from the divider
  task automatic lf(input logic add, input logic [7:0] step);
    logic [8:0] sum;
    @(posedge sys_clk);
    lf_add <= add;
    lf_sub <= ~add;
    lf_step <= step;
    @(posedge sys_clk);
    lf_add <= 1'b0;
    lf_sub <= 1'b0;
    sum = add ? {1'b0, m_stage} + step : {1'b0, m_stage} - step;
    if (sum[8] && add && m_div != 4'hF)
      m_div = m_div + 4'h1;
    if (sum[8] && !add && m_div != 4'h0)
      m_div = m_div - 4'h1;
    m_stage = sum[7:0];
    lf_q.push_back({m_div, m_stage});
  endtask : lf

  // Cycles between ticks; the first count only synchronises
  task automatic tick_period(input int exp);
    for (int k = 0; k < 3; k++)
    begin
      n = 1;
      @(posedge sys_clk);
      while (dco_tick !== 1'b1 && n < 1100)
      begin
        n++;
        @(posedge sys_clk);
      end
    end
    if (n >= 1100)
      timeout();
    `CMDD_CHK(n, exp)
  endtask : tick_period

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    void'($urandom(84274));
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(CMDD_CTRL_OFFS, 32'h08);
    rd(CMDD_DCO_OFFS, 32'h080);
    rd(8'h10, 32'h0, 1'b1);
    int_stable <= 1'b1;
    ext_stable <= 1'b1;
    rd(CMDD_CTRL_OFFS, 32'h0C);
    // Monitor refused until the alternate clock runs and is stable
    wr(CMDD_CTRL_OFFS, 32'hAF);
    rd(CMDD_CTRL_OFFS, 32'h0F);
    wr(CMDD_CTRL_OFFS, 32'h8F);
    rd(CMDD_CTRL_OFFS, 32'h0F);
    int_stable <= 1'b0;
    ext_stable <= 1'b0;
    wr(CMDD_CTRL_OFFS, 32'hAF);
    rd(CMDD_CTRL_OFFS, 32'h0A);
    int_stable <= 1'b1;
    ext_stable <= 1'b1;
    wr(CMDD_CTRL_OFFS, 32'h1F);
    rd(CMDD_CTRL_OFFS, 32'h1F);
    `CMDD_CHK(osc_sel, 1'b1)
    wr(CMDD_CTRL_OFFS, 32'hAF);
    rd(CMDD_CTRL_OFFS, 32'h2F);
    `CMDD_CHK(osc_sel, 1'b0)
    wr(CMDD_CTRL_OFFS, 32'hAF);
    rd(CMDD_CTRL_OFFS, 32'hAF);
    int_stable <= 1'b0;
    ext_stable <= 1'b0;
    rd(CMDD_CTRL_OFFS, 32'hAA);
    int_stable <= 1'b1;
    ext_stable <= 1'b1;
    wr(CMDD_IMSK_OFFS, 32'h01);
    // Internal base clock stops: the monitor must fall back
    int_run <= 1'b0;
    n = 0;
    while (mon_irq !== 1'b1 && n < 1000)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 1000)
      timeout();
    repeat (3) @(posedge sys_clk);
    `CMDD_CHK(osc_sel, 1'b1)
    `CMDD_CHK(tb_sel, 1'b1)
    `CMDD_CHK({int_on, ext_on}, 2'h3)
    `CMDD_CHK(irq, 1'b1)
    int_run <= 1'b1;
    repeat (300) @(posedge sys_clk);
    wr(CMDD_CTRL_OFFS, 32'hBF);
    rd(CMDD_CTRL_OFFS, 32'hFF);
    wr(CMDD_CTRL_OFFS, 32'hFF);
    rd(CMDD_CTRL_OFFS, 32'hFF);
    wr(CMDD_CTRL_OFFS, 32'hBF);
    rd(CMDD_CTRL_OFFS, 32'hBF);
    repeat (2) @(posedge sys_clk);
    `CMDD_CHK(mon_irq, 1'b0)
    `CMDD_CHK(irq, 1'b1)
    wr(CMDD_CTRL_OFFS, 32'h1F);
    rd(CMDD_CTRL_OFFS, 32'h1F);
    wr(CMDD_IMSK_OFFS, 32'h00);
    repeat (2) @(posedge sys_clk);
    `CMDD_CHK(irq, 1'b0)
    wr(CMDD_IMSK_OFFS, 32'h07);
    rd(CMDD_ISTS_OFFS, 32'h03);
    wr(CMDD_ISTS_OFFS, 32'h07);
    rd(CMDD_ISTS_OFFS, 32'h00);
    rd(CMDD_IMSK_OFFS, 32'h07);
    `CMDD_CHK(irq, 1'b0)
    // External clock dies while selected: both muxes go internal
    wr(CMDD_CTRL_OFFS, 32'hBF);
    rd(CMDD_CTRL_OFFS, 32'h3F);
    wr(CMDD_CTRL_OFFS, 32'hBF);
    rd(CMDD_CTRL_OFFS, 32'hBF);
    ext_run <= 1'b0;
    n = 0;
    while (osc_sel !== 1'b0 && n < 1000)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 1000)
      timeout();
    repeat (3) @(posedge sys_clk);
    `CMDD_CHK({tb_sel, mon_irq}, 2'h1)
    rd(CMDD_CTRL_OFFS, 32'hEE);
    ext_run <= 1'b1;
    repeat (300) @(posedge sys_clk);
    // Handler: read to arm, then clear flag and monitor together
    rd(CMDD_CTRL_OFFS, 32'hEF);
    wr(CMDD_CTRL_OFFS, 32'h0F);
    rd(CMDD_CTRL_OFFS, 32'h0F);
    `CMDD_CHK(tb_sel, 1'b1)
    rd(CMDD_ISTS_OFFS, 32'h05);
    `CMDD_CHK(irq, 1'b1)
    // Divider sweep: two half-range adds give exactly one carry
    for (int d = 0; d < 16; d++)
    begin
      tick_period(1 << ((d > 9) ? 9 : d));
      if (d < 15)
      begin
        lf(1'b1, 8'h80);
        lf(1'b1, 8'h80);
      end
    end
    rd(CMDD_DCO_OFFS, {20'h0, m_div, m_stage});
    // Random filter steps, two in three subtracting, walk the divider down
    repeat (60)
      lf(($urandom % 3) == 0, 8'($urandom));
    rd(CMDD_DCO_OFFS, {20'h0, m_div, m_stage});
    results();
  end
endmodule : cmdd_top_test
`undef CMDD_CHK
`default_nettype wire

//--- verilog/cmdd_pkg.sv
`default_nettype none
package cmdd_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ------------------------------------------------------------
  localparam logic [7:0] CMDD_CTRL_OFFS = 8'h00;
  localparam logic [7:0] CMDD_ISTS_OFFS = 8'h04;
  localparam logic [7:0] CMDD_IMSK_OFFS = 8'h08;
  localparam logic [7:0] CMDD_DCO_OFFS = 8'h0C;

  // ------------------------------------------------------------
  // Control register bit positions
  // ------------------------------------------------------------
  localparam int CTRL_IRQ_EN_BIT = 7;
  localparam int CTRL_FLAG_BIT = 6;
  localparam int CTRL_MON_EN_BIT = 5;
  localparam int CTRL_CS_BIT = 4;
  localparam int CTRL_INT_ON_BIT = 3;
  localparam int CTRL_INT_ST_BIT = 2;
  localparam int CTRL_EXT_ON_BIT = 1;
  localparam int CTRL_EXT_ST_BIT = 0;

  // ------------------------------------------------------------
  // Interrupt status bits and field positions
  // ------------------------------------------------------------
  localparam int ISTS_FLAG_BIT = 0;
  localparam int ISTS_INT_OFF_BIT = 1;
  localparam int ISTS_EXT_OFF_BIT = 2;
  localparam int DCO_DIV_POS = 8;

  // ------------------------------------------------------------
  // Reset values, divider limit and inactivity miss limit
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam logic [7:0] STAGE_RST = 8'h80;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] DIV_MAX_EFF = 4'h9;
  localparam logic [1:0] MISS_LIMIT = 2'h2;

  // Synchroniser lanes of the pin inputs
  localparam int PIN_INT_BASE = 0;
  localparam int PIN_EXT_REF = 1;
  localparam int PIN_EXT_CLK = 2;
  localparam int PIN_INT_REF = 3;

endpackage : cmdd_pkg
`default_nettype wire

//--- verilog/cmdd_top.sv
// Notes on behaviour
// - Monitor enable sets only with both generators on and both stable.
// - Monitor interrupt enable cannot set while monitor enable is clear.
// - Monitor flag is readable at control bit 6.
// - Control bits 7..0: irq en, flag, mon en, select, on/stable pairs.
// - Flag clears by writing zero after a read saw it set.
// - Monitor enable stays set when a clock later loses stability.
// - On inactivity the dead clock is deselected for both clock muxes.
// - Internal period is set by stage and divider control only.
// - Divider divides by two to the divider code, codes above 9 as 9.
// - Up to code 9, each divider increment doubles the period, decrement halves it.
// - Divider moves only on carry or borrow of the stage control.
// - Clock select set picks external clock, clear picks internal.
// - Inactive after two ref low phases without edge; edge clears it.
`timescale 1ns/1ns
`default_nettype none
module cmdd_top
(
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Activity pins from the clock generators
  input wire logic INT_BASE_IN,
  input wire logic EXT_REF_IN,
  input wire logic EXT_CLK_IN,
  input wire logic INT_REF_IN,
  input wire logic INTERNAL_STABLE_IN,
  input wire logic EXTERNAL_STABLE_IN,
  // Loop filter steps
  input wire logic LF_ADD_IN,
  input wire logic LF_SUB_IN,
  input wire logic [7:0] LF_STEP_IN,
  // Clock generator controls
  output logic INTERNAL_GEN_ON_OUT,
  output logic EXTERNAL_GEN_ON_OUT,
  output logic OSC_SEL_EXT_OUT,
  output logic TIMEBASE_SEL_EXT_OUT,
  output logic [7:0] STAGE_CONTROL_OUT,
  output logic [3:0] DIVIDER_CONTROL_OUT,
  output logic DCO_TICK_OUT,
  // Interrupts
  output logic MONITOR_IRQ_OUT,
  output logic IRQ_OUT
);
  import cmdd_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic flag_armed;
    logic [2:0] ists;
    logic [2:0] imsk;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] flt;
    logic [3:0] idet;
    logic [3:0] edet;
    logic [7:0] stage;
    logic [3:0] div;
    logic [8:0] div_cnt;
    logic tick;
    logic osc_sel;
    logic tb_sel;
    logic mon_irq;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cmdd_state_t;

  cmdd_state_t st_ff;
  cmdd_state_t nxt_st;

  // ------------------------------------------------------------
  // Activity detector step
  // ------------------------------------------------------------
  // Packing of cur: {inactive, miss[1:0], seen}
  function automatic logic [3:0] cmdd_det_step(input logic mon_fall,
    input logic ref_low, input logic ref_rise, input logic [3:0] cur);
    logic inact;
    logic [1:0] miss;
    logic seen;
    inact = cur[3];
    miss = cur[2:1];
    seen = cur[0];
    if (mon_fall && ref_low)
    begin
      inact = 1'b0;
      miss = 2'h0;
      seen = 1'b1;
    end
    else if (ref_rise)
    begin
      // End of a reference low phase: count it if it held no edge
      if (seen)
        miss = 2'h0;
      else if (miss != MISS_LIMIT)
        miss = miss + 2'h1;
      inact = inact | (miss == MISS_LIMIT);
      seen = 1'b0;
    end
    return {inact, miss, seen};
  endfunction : cmdd_det_step

  // Divider terminal count: 2**code - 1, codes above 9 behave as 9
  function automatic logic [8:0] cmdd_div_limit(input logic [3:0] code);
    logic [3:0] eff;
    eff = (code > DIV_MAX_EFF) ? DIV_MAX_EFF : code;
    return (9'h001 << eff) - 9'h001;
  endfunction : cmdd_div_limit

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [3:0] fall;
    logic [3:0] rise;
    logic acc;
    logic done;
    logic wr_ctrl;
    logic [7:0] w;
    logic [7:0] c;
    logic both_on;
    logic hit;
    logic [31:0] rdata;
    logic [8:0] sum;
    logic [2:0] ev;
    logic i_off;
    logic e_off;
    fall = 4'h0;
    rise = 4'h0;
    rdata = 32'h0;
    sum = 9'h000;
    nxt_st = st_ff;
    // Bus decode and current control value, settled before any use
    ev = 3'h0;
    i_off = st_ff.idet[3];
    e_off = st_ff.edet[3];
    c = st_ff.ctrl;
    w = PWDATA_IN[7:0];
    both_on = c[CTRL_INT_ON_BIT] && c[CTRL_EXT_ON_BIT];
    acc = PSEL_IN && PENABLE_IN;
    done = acc && st_ff.pready;
    wr_ctrl = done && PWRITE_IN && (PADDR_IN == CMDD_CTRL_OFFS);
    hit = (PADDR_IN == CMDD_CTRL_OFFS) || (PADDR_IN == CMDD_ISTS_OFFS) ||
      (PADDR_IN == CMDD_IMSK_OFFS) || (PADDR_IN == CMDD_DCO_OFFS);

    // Pins pass three flops; a level counts once stages two and three agree
    nxt_st.s1 = {INT_REF_IN, EXT_CLK_IN, EXT_REF_IN, INT_BASE_IN};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < 4; i++)
    begin
      if (st_ff.s2[i] == st_ff.s3[i])
        nxt_st.flt[i] = st_ff.s3[i];
    end
    fall = st_ff.flt & ~nxt_st.flt;
    rise = ~st_ff.flt & nxt_st.flt;

    // Each clock is checked against the other side's reference
    nxt_st.idet = cmdd_det_step(fall[PIN_INT_BASE], !st_ff.flt[PIN_EXT_REF],
      rise[PIN_EXT_REF], st_ff.idet);
    nxt_st.edet = cmdd_det_step(fall[PIN_EXT_CLK], !st_ff.flt[PIN_INT_REF],
      rise[PIN_INT_REF], st_ff.edet);

    // APB: access phase lasts two cycles, pready comes from a flop
    unique case (PADDR_IN)
      CMDD_CTRL_OFFS: rdata = {24'h0, st_ff.ctrl};
      CMDD_ISTS_OFFS: rdata = {29'h0, st_ff.ists};
      CMDD_IMSK_OFFS: rdata = {29'h0, st_ff.imsk};
      CMDD_DCO_OFFS: rdata = {20'h0, st_ff.div, st_ff.stage};
      default: rdata = 32'h0;
    endcase
    nxt_st.pready = acc && !st_ff.pready;
    nxt_st.pslverr = acc && !st_ff.pready && !hit;
    nxt_st.prdata = (acc && !st_ff.pready && !PWRITE_IN) ? rdata : 32'h0;

    // Control register write with its interlocks
    if (wr_ctrl)
    begin
      // Interrupt enable needs monitor enable already set
      nxt_st.ctrl[CTRL_IRQ_EN_BIT] = w[CTRL_IRQ_EN_BIT] &&
        c[CTRL_MON_EN_BIT];
      if (!w[CTRL_MON_EN_BIT])
      begin
        nxt_st.ctrl[CTRL_MON_EN_BIT] = 1'b0;
        nxt_st.ctrl[CTRL_IRQ_EN_BIT] = 1'b0;
      end
      else if (both_on && c[CTRL_INT_ST_BIT] && c[CTRL_EXT_ST_BIT])
        nxt_st.ctrl[CTRL_MON_EN_BIT] = 1'b1;
      // Select moves only to a running, stable clock
      if (both_on && (w[CTRL_CS_BIT] ? c[CTRL_EXT_ST_BIT] :
        c[CTRL_INT_ST_BIT]))
        nxt_st.ctrl[CTRL_CS_BIT] = w[CTRL_CS_BIT];
      // The selected generator cannot be switched off under its own clock
      nxt_st.ctrl[CTRL_INT_ON_BIT] = w[CTRL_INT_ON_BIT] || !c[CTRL_CS_BIT];
      nxt_st.ctrl[CTRL_EXT_ON_BIT] = w[CTRL_EXT_ON_BIT] || c[CTRL_CS_BIT];
      // Writing one leaves the flag; zero clears it only after a read
      if (!w[CTRL_FLAG_BIT] && st_ff.flag_armed)
      begin
        nxt_st.ctrl[CTRL_FLAG_BIT] = 1'b0;
        nxt_st.flag_armed = 1'b0;
      end
    end
    if (done && !PWRITE_IN && (PADDR_IN == CMDD_CTRL_OFFS) &&
      c[CTRL_FLAG_BIT])
      nxt_st.flag_armed = 1'b1;

    // Inactivity while monitoring sets the flag; set beats a clear
    if (c[CTRL_MON_EN_BIT] && (i_off || e_off))
      nxt_st.ctrl[CTRL_FLAG_BIT] = 1'b1;

    // Fall back to the live clock; this beats a select write
    if (c[CTRL_MON_EN_BIT] && e_off && !i_off)
      nxt_st.ctrl[CTRL_CS_BIT] = 1'b0;
    if (c[CTRL_MON_EN_BIT] && i_off && !e_off)
      nxt_st.ctrl[CTRL_CS_BIT] = 1'b1;

    // Stable bits follow the generators live; monitor enable and select writes check them
    nxt_st.ctrl[CTRL_INT_ST_BIT] = INTERNAL_STABLE_IN &&
      nxt_st.ctrl[CTRL_INT_ON_BIT] && !nxt_st.idet[3];
    nxt_st.ctrl[CTRL_EXT_ST_BIT] = EXTERNAL_STABLE_IN &&
      nxt_st.ctrl[CTRL_EXT_ON_BIT] && !nxt_st.edet[3];

    // Clock muxes: timebase follows the external on bit unless forced
    nxt_st.osc_sel = nxt_st.ctrl[CTRL_CS_BIT];
    nxt_st.tb_sel = nxt_st.ctrl[CTRL_EXT_ON_BIT];
    if (c[CTRL_MON_EN_BIT] && e_off)
      nxt_st.tb_sel = 1'b0;
    else if (c[CTRL_MON_EN_BIT] && i_off)
      nxt_st.tb_sel = 1'b1;

    // Sticky event status, write one to clear, new events win
    ev[ISTS_FLAG_BIT] = nxt_st.ctrl[CTRL_FLAG_BIT] && !c[CTRL_FLAG_BIT];
    ev[ISTS_INT_OFF_BIT] = nxt_st.idet[3] && !i_off;
    ev[ISTS_EXT_OFF_BIT] = nxt_st.edet[3] && !e_off;
    if (done && PWRITE_IN && (PADDR_IN == CMDD_ISTS_OFFS))
      nxt_st.ists = st_ff.ists & ~PWDATA_IN[2:0];
    if (done && PWRITE_IN && (PADDR_IN == CMDD_IMSK_OFFS))
      nxt_st.imsk = PWDATA_IN[2:0];
    nxt_st.ists = nxt_st.ists | ev;
    nxt_st.irq = |(nxt_st.ists & nxt_st.imsk);
    nxt_st.mon_irq = nxt_st.ctrl[CTRL_FLAG_BIT] &&
      nxt_st.ctrl[CTRL_IRQ_EN_BIT];

    // Loop filter moves the stage; divider follows carry and borrow only
    if (LF_ADD_IN)
    begin
      sum = {1'b0, st_ff.stage} + {1'b0, LF_STEP_IN};
      nxt_st.stage = sum[7:0];
      if (sum[8] && (st_ff.div != 4'hF))
        nxt_st.div = st_ff.div + 4'h1;
    end
    else if (LF_SUB_IN)
    begin
      sum = {1'b0, st_ff.stage} - {1'b0, LF_STEP_IN};
      nxt_st.stage = sum[7:0];
      if (sum[8] && (st_ff.div != 4'h0))
        nxt_st.div = st_ff.div - 4'h1;
    end

    // Binary weighted divider: one tick per 2**code cycles, codes above 9 as 9
    if (st_ff.div_cnt >= cmdd_div_limit(st_ff.div))
    begin
      nxt_st.div_cnt = 9'h000;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.div_cnt = st_ff.div_cnt + 9'h001;
      nxt_st.tick = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Synchronous reset; only constants are loaded
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RST;
      st_ff.stage <= STAGE_RST;
      st_ff.div <= DIV_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from flops
  assign PRDATA_OUT = st_ff.prdata;
  assign PREADY_OUT = st_ff.pready;
  assign PSLVERR_OUT = st_ff.pslverr;
  assign INTERNAL_GEN_ON_OUT = st_ff.ctrl[CTRL_INT_ON_BIT];
  assign EXTERNAL_GEN_ON_OUT = st_ff.ctrl[CTRL_EXT_ON_BIT];
  assign OSC_SEL_EXT_OUT = st_ff.osc_sel;
  assign TIMEBASE_SEL_EXT_OUT = st_ff.tb_sel;
  assign STAGE_CONTROL_OUT = st_ff.stage;
  assign DIVIDER_CONTROL_OUT = st_ff.div;
  assign DCO_TICK_OUT = st_ff.tick;
  assign MONITOR_IRQ_OUT = st_ff.mon_irq;
  assign IRQ_OUT = st_ff.irq;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_mon_en_guard:
    assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      $rose(st_ff.ctrl[CTRL_MON_EN_BIT]) |->
      $past(st_ff.ctrl[CTRL_INT_ST_BIT]) &&
      $past(st_ff.ctrl[CTRL_EXT_ST_BIT]))
    else $error("monitor enable set without both clocks stable");

  a_irq_en_needs_mon:
    assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      $rose(st_ff.ctrl[CTRL_IRQ_EN_BIT]) |->
      $past(st_ff.ctrl[CTRL_MON_EN_BIT]))
    else $error("irq enable set while monitor was off");

  a_flag_clear_cause:
    assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      $fell(st_ff.ctrl[CTRL_FLAG_BIT]) |->
      $past(st_ff.flag_armed && PWRITE_IN && !PWDATA_IN[CTRL_FLAG_BIT]))
    else $error("monitor flag cleared without read then zero write");

  a_mon_en_sticky:
    assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      $fell(st_ff.ctrl[CTRL_MON_EN_BIT]) |->
      $past(PSEL_IN && PENABLE_IN && st_ff.pready && PWRITE_IN))
    else $error("monitor enable dropped without a write");

  a_fallback_int:
    assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      st_ff.ctrl[CTRL_MON_EN_BIT] && st_ff.edet[3] && !st_ff.idet[3]
      |=> !st_ff.ctrl[CTRL_CS_BIT] && !TIMEBASE_SEL_EXT_OUT
      ##1 !OSC_SEL_EXT_OUT)
    else $error("dead external clock stayed selected");

  a_flag_sets_irq:
    assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      st_ff.ctrl[CTRL_MON_EN_BIT] && st_ff.idet[3]
      |=> st_ff.ctrl[CTRL_FLAG_BIT] &&
      (MONITOR_IRQ_OUT == st_ff.ctrl[CTRL_IRQ_EN_BIT]))
    else $error("inactivity did not raise flag and irq");

  a_div_on_carry:
    assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      $changed(st_ff.div) |->
      $past(LF_ADD_IN || LF_SUB_IN) && $changed(st_ff.stage))
    else $error("divider moved without stage carry or borrow");

  a_div_zero_tick:
    assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (st_ff.div == 4'h0) [*3] |-> DCO_TICK_OUT)
    else $error("divide by one missed a tick");

  a_inact_clear:
    assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      $fell(st_ff.flt[PIN_INT_BASE]) && !$past(st_ff.flt[PIN_EXT_REF])
      |-> !st_ff.idet[3])
    else $error("internal inactive held after a seen edge");

endmodule : cmdd_top
`default_nettype wire
